// ===== pkg/fcr_defines.vh
// Register map, field positions, reset values and codes of the floppy configuration bank
`ifndef FCR_DEFINES_VH
`define FCR_DEFINES_VH
// Register indices; byte address is four times the index
`define FCR_IDX_ACT      8'h30
`define FCR_IDX_BASE_HI  8'h60
`define FCR_IDX_BASE_LO  8'h61
`define FCR_IDX_IRQ      8'h70
`define FCR_IDX_DMA      8'h74
`define FCR_IDX_MODE     8'hf0
`define FCR_IDX_MEDIA    8'hf1
`define FCR_IDX_DTYPE_A  8'hf2
`define FCR_IDX_RATE0    8'hf4
`define FCR_IDX_RATE1    8'hf5
// Reset values (reserved bits excluded)
`define FCR_RST_ACT      8'h01
`define FCR_RST_BASE_HI  8'h03
`define FCR_RST_BASE_LO  8'hf0
`define FCR_RST_IRQ      8'h06
`define FCR_RST_DMA      8'h02
`define FCR_RST_MODE     8'h0e
`define FCR_RST_MEDIA    8'h00
`define FCR_RST_DTYPE_A  8'h03
`define FCR_RST_RATE     8'h00
// Writable masks; everything else reads zero
`define FCR_MSK_ACT      8'h01
`define FCR_MSK_BASE_HI  8'h0f
`define FCR_MSK_BASE_LO  8'hf8
`define FCR_MSK_IRQ      8'h0f
`define FCR_MSK_DMA      8'h07
`define FCR_MSK_MODE     8'h7f
`define FCR_MSK_MEDIA    8'hff
`define FCR_MSK_DTYPE_A  8'h03
`define FCR_MSK_RATE     8'h5b
// Field positions
`define FCR_ACT_BIT      0
`define FCR_DMA_OFF_BIT  2
`define FCR_POL_BIT      6
`define FCR_NO2ND_BIT    5
`define FCR_SWAP_BIT     4
`define FCR_IMODE_HI     3
`define FCR_IMODE_LO     2
`define FCR_NBURST_BIT   1
`define FCR_ENH_BIT      0
`define FCR_BOOT_HI      7
`define FCR_BOOT_LO      6
`define FCR_MID_HI       5
`define FCR_MID_LO       4
`define FCR_DSEL_HI      3
`define FCR_DSEL_LO      2
`define FCR_WINH_BIT     1
`define FCR_WPF_BIT      0
`define FCR_PCOMP_BIT    6
`define FCR_TSEL_HI      4
`define FCR_TSEL_LO      3
`define FCR_DTYP_HI      1
`define FCR_DTYP_LO      0
// Interface personalities
`define FCR_IF_COMPACT   2'h0
`define FCR_IF_SECOND    2'h1
`define FCR_IF_RSVD      2'h2
`define FCR_IF_AT        2'h3
// Rate tables
`define FCR_TBL_REGULAR  2'h0
`define FCR_TBL_3MODE    2'h1
`define FCR_TBL_TAPE     2'h2
`define FCR_TBL_RSVD     2'h3
// Density forcing
`define FCR_DEN_FORCE1   2'h2
`define FCR_DEN_FORCE0   2'h3
// Drive type steering of the density pin
`define FCR_DT_RATE1     2'h1
`define FCR_DT_RATE0     2'h3
// Selected data rate codes (MODIFIED_FREQ_MODULATION figure; FM is half where it exists)
`define FCR_RATE_1M      3'h0
`define FCR_RATE_500K    3'h1
`define FCR_RATE_300K    3'h2
`define FCR_RATE_250K    3'h3
`define FCR_RATE_2M      3'h4
// Base window limit
`define FCR_BASE_MIN     12'h100
`endif

// ===== rtl/fcr_floppy_config.v
// Floppy controller configuration bank with Wishbone slave and drive-pin steering
//
// Function
// - Activation bit 0 low keeps the controller inactive; high activates it.
// - Two base bytes form the I/O base, 100h to FF8h, 8-byte aligned.
// - Low four bits of interrupt select choose the line; upper bits reserved.
// - DMA codes 000-011 pick channels 0-3; top bit set disables DMA.
// - Polarity bit 6 low: drive signals active low; high: active high.
// - Mode bit 5 low reports a second drive, in second personality only.
// - Swap bit 4 high exchanges drive and motor selects of drives 0 and 1.
// - Interface mode codes 00, 01, 11 pick personalities; 10 reserved.
// - DMA mode bit 1 low gives burst transfers; high gives non-burst.
// - Mode bit 0 low is normal floppy mode; high is three-mode.
// - Boot drive code 00 means drive A; other codes reserved.
// - Media ID bits 5:4 appear as tape register bits 7:6.
// - Density codes 00,01 normal; 10 forces 1; 11 forces 0.
// - Write inhibit high holds write gate and write data pins high.
// - Forced protect low uses write-protect input; high always protected.
// - Precompensation bit 6 low enables precompensation; high disables it.
// - Table select: 00 regular, 01 three-mode, 10 tape, 11 reserved.
// - Regular table: 00 500K, 01 300K, 10 250K, 11 1Meg.
// - Three-mode code 01 is 500K; tape code 01 is 2Meg.
// - Drive type steers density pin: select, rate bit 1, select, rate bit 0.
`timescale 1ns/1ps
`include "fcr_defines.vh"

module fcr_floppy_config
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [9:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Controller core side, active high inside the chip
    input  wire [1:0]  core_drive_sel_i,
    input  wire [1:0]  core_motor_i,
    input  wire        core_write_gate_i,
    input  wire        core_write_data_i,
    input  wire        core_unit_i,
    input  wire        density_select_signal_i,
    input  wire        rate_bit1_i,
    input  wire        rate_bit0_i,
    // Drive pin from outside the clock domain
    input  wire        write_protect_pin_i,
    // Configuration presented to the controller core
    output reg         ctrl_active_o,
    output reg  [11:0] io_base_o,
    output reg         io_base_valid_o,
    output reg  [3:0]  irq_line_o,
    output reg         dma_enable_o,
    output reg  [1:0]  dma_channel_o,
    output reg  [1:0]  intf_mode_o,
    output reg         second_drive_o,
    output reg         dma_burst_o,
    output reg         three_mode_o,
    output reg         boot_drive_a_o,
    output reg  [1:0]  tape_media_id_o,
    output reg         precomp_enable_o,
    output reg  [2:0]  data_rate_o,
    output reg         write_protected_o,
    // Drive pins
    output reg  [1:0]  drive_sel_pin_o,
    output reg  [1:0]  motor_pin_o,
    output reg         write_gate_pin_o,
    output reg         write_data_pin_o,
    output reg         density_output_pin_o
);

////////////////////////////////////////////////////////////////////////////////
// Register storage

reg  [7:0] act;
reg  [7:0] base_hi;
reg  [7:0] base_lo;
reg  [7:0] irq_sel;
reg  [7:0] dma_sel;
reg  [7:0] mode;
reg  [7:0] media;
reg  [7:0] dtype_a;
reg  [7:0] rate0;
reg  [7:0] rate1;

wire [7:0] idx = adr_i[9:2];
wire       req = cyc_i & stb_i;
wire       wr  = req & we_i & ack_o & sel_i[0];
wire [7:0] wd  = dat_i[7:0];

// Accepts a new value of a masked field, leaving reserved bits at zero
function [7:0] merge;
    input [7:0] val;
    input [7:0] msk;
    begin
        merge = val & msk;
    end
endfunction

// Write lands at the edge where the master samples ack, so data held until then is the data used
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        act     <= `FCR_RST_ACT;
        base_hi <= `FCR_RST_BASE_HI;
        base_lo <= `FCR_RST_BASE_LO;
        irq_sel <= `FCR_RST_IRQ;
        dma_sel <= `FCR_RST_DMA;
        mode    <= `FCR_RST_MODE;
        media   <= `FCR_RST_MEDIA;
        dtype_a <= `FCR_RST_DTYPE_A;
        rate0   <= `FCR_RST_RATE;
        rate1   <= `FCR_RST_RATE;
    end
    else if (wr)
    begin
        case (idx)
            `FCR_IDX_ACT:     act     <= merge(wd, `FCR_MSK_ACT);
            `FCR_IDX_BASE_HI: base_hi <= merge(wd, `FCR_MSK_BASE_HI);
            `FCR_IDX_BASE_LO: base_lo <= merge(wd, `FCR_MSK_BASE_LO);
            `FCR_IDX_IRQ:     irq_sel <= merge(wd, `FCR_MSK_IRQ);
            `FCR_IDX_DMA:     dma_sel <= merge(wd, `FCR_MSK_DMA);
            `FCR_IDX_MODE:
            begin
                // Reserved personality code keeps the previous one
                if (wd[`FCR_IMODE_HI:`FCR_IMODE_LO] == `FCR_IF_RSVD)
                    mode <= {1'b0, wd[6:4], mode[`FCR_IMODE_HI:`FCR_IMODE_LO], wd[1:0]};
                else
                    mode <= merge(wd, `FCR_MSK_MODE);
            end
            `FCR_IDX_MEDIA:   media   <= merge(wd, `FCR_MSK_MEDIA);
            `FCR_IDX_DTYPE_A: dtype_a <= merge(wd, `FCR_MSK_DTYPE_A);
            `FCR_IDX_RATE0:   rate0   <= merge(wd, `FCR_MSK_RATE);
            `FCR_IDX_RATE1:   rate1   <= merge(wd, `FCR_MSK_RATE);
            default:          act     <= act;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus answer: ack one cycle after the request, dropped the cycle after

reg [7:0] next_rd;

always @*
begin
    case (idx)
        `FCR_IDX_ACT:     next_rd = act;
        `FCR_IDX_BASE_HI: next_rd = base_hi;
        `FCR_IDX_BASE_LO: next_rd = base_lo;
        `FCR_IDX_IRQ:     next_rd = irq_sel;
        `FCR_IDX_DMA:     next_rd = dma_sel;
        `FCR_IDX_MODE:    next_rd = mode;
        `FCR_IDX_MEDIA:   next_rd = media;
        `FCR_IDX_DTYPE_A: next_rd = dtype_a;
        `FCR_IDX_RATE0:   next_rd = rate0;
        `FCR_IDX_RATE1:   next_rd = rate1;
        default:          next_rd = 8'h00;
    endcase
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
    end
    else
    begin
        ack_o <= req & ~ack_o;
        if (req & ~ack_o)
            dat_o <= {24'h000000, next_rd};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write-protect pin synchroniser; a change counts once stages two and three agree

reg [2:0] wp_sync;
reg       wp_level;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wp_sync  <= 3'h0;
        wp_level <= 1'b0;
    end
    else
    begin
        wp_sync <= {wp_sync[1:0], write_protect_pin_i};
        if (wp_sync[2] == wp_sync[1])
            wp_level <= wp_sync[1];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Decoded configuration

wire       pol_high  = mode[`FCR_POL_BIT];
wire       swap      = mode[`FCR_SWAP_BIT];
wire [1:0] imode     = mode[`FCR_IMODE_HI:`FCR_IMODE_LO];
wire [1:0] den_force = media[`FCR_DSEL_HI:`FCR_DSEL_LO];
wire       winh      = media[`FCR_WINH_BIT];
wire [7:0] rate_cfg  = core_unit_i ? rate1 : rate0;
wire [1:0] tsel      = rate_cfg[`FCR_TSEL_HI:`FCR_TSEL_LO];
// Drive A type register also steers drive 0 when the per-drive field is left at zero
wire [1:0] dtype     = (core_unit_i || rate_cfg[`FCR_DTYP_HI:`FCR_DTYP_LO] != 2'h0)
                       ? rate_cfg[`FCR_DTYP_HI:`FCR_DTYP_LO]
                       : dtype_a[`FCR_DTYP_HI:`FCR_DTYP_LO];
wire [1:0] rate      = {rate_bit1_i, rate_bit0_i};
wire [11:0] base     = {base_hi[3:0], base_lo};

// Polarity applied on the way out and on the way in
wire       pin_invert = ~pol_high;
wire       wp_active  = wp_level ^ pin_invert;
wire [1:0] sel_sw     = swap ? {core_drive_sel_i[0], core_drive_sel_i[1]} : core_drive_sel_i;
wire [1:0] mot_sw     = swap ? {core_motor_i[0], core_motor_i[1]} : core_motor_i;

reg        next_den_sig;
reg        next_den_pin;
reg  [2:0] next_rate;

always @*
begin
    case (den_force)
        `FCR_DEN_FORCE1: next_den_sig = 1'b1;
        `FCR_DEN_FORCE0: next_den_sig = 1'b0;
        default:         next_den_sig = density_select_signal_i;
    endcase
    case (dtype)
        `FCR_DT_RATE1:   next_den_pin = rate_bit1_i;
        `FCR_DT_RATE0:   next_den_pin = rate_bit0_i;
        default:         next_den_pin = next_den_sig;
    endcase
    case (rate)
        2'h0:    next_rate = `FCR_RATE_500K;
        2'h2:    next_rate = `FCR_RATE_250K;
        2'h3:    next_rate = `FCR_RATE_1M;
        default:
        begin
            // Only code 01 differs between the tables
            case (tsel)
                `FCR_TBL_3MODE: next_rate = `FCR_RATE_500K;
                `FCR_TBL_TAPE:  next_rate = `FCR_RATE_2M;
                default:        next_rate = `FCR_RATE_300K;
            endcase
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs; core signals pay one cycle of latency so every pin comes from a flop

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ctrl_active_o        <= 1'b0;
        io_base_o            <= 12'h000;
        io_base_valid_o      <= 1'b0;
        irq_line_o           <= 4'h0;
        dma_enable_o         <= 1'b0;
        dma_channel_o        <= 2'h0;
        intf_mode_o          <= `FCR_IF_AT;
        second_drive_o       <= 1'b0;
        dma_burst_o          <= 1'b1;
        three_mode_o         <= 1'b0;
        boot_drive_a_o       <= 1'b1;
        tape_media_id_o      <= 2'h0;
        precomp_enable_o     <= 1'b1;
        data_rate_o          <= `FCR_RATE_500K;
        write_protected_o    <= 1'b0;
        drive_sel_pin_o      <= 2'h3;
        motor_pin_o          <= 2'h3;
        write_gate_pin_o     <= 1'b1;
        write_data_pin_o     <= 1'b1;
        density_output_pin_o <= 1'b0;
    end
    else
    begin
        ctrl_active_o     <= act[`FCR_ACT_BIT];
        io_base_o         <= base;
        io_base_valid_o   <= (base >= `FCR_BASE_MIN);
        irq_line_o        <= irq_sel[3:0];
        dma_enable_o      <= ~dma_sel[`FCR_DMA_OFF_BIT];
        dma_channel_o     <= dma_sel[1:0];
        intf_mode_o       <= imode;
        second_drive_o    <= (imode == `FCR_IF_SECOND) & ~mode[`FCR_NO2ND_BIT];
        dma_burst_o       <= ~mode[`FCR_NBURST_BIT];
        three_mode_o      <= mode[`FCR_ENH_BIT];
        boot_drive_a_o    <= (media[`FCR_BOOT_HI:`FCR_BOOT_LO] == 2'h0);
        tape_media_id_o   <= media[`FCR_MID_HI:`FCR_MID_LO];
        precomp_enable_o  <= ~rate_cfg[`FCR_PCOMP_BIT];
        data_rate_o       <= next_rate;
        write_protected_o <= media[`FCR_WPF_BIT] | wp_active;
        drive_sel_pin_o   <= sel_sw ^ {2{pin_invert}};
        motor_pin_o       <= mot_sw ^ {2{pin_invert}};
        // Inhibit pins the level high regardless of polarity, as the drive expects
        write_gate_pin_o  <= winh | (core_write_gate_i ^ pin_invert);
        write_data_pin_o  <= winh | (core_write_data_i ^ pin_invert);
        density_output_pin_o <= next_den_pin;
    end
end

endmodule

// ===== tb/fcr_floppy_config_asserts.sv
// Port-level assertions for the floppy configuration bank
`timescale 1ns/1ps
module fcr_floppy_config_asserts
(
    // Clock, reset and bus
    input logic        clk_i,
    input logic        rst_i,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        ack_o,
    input logic [31:0] dat_o,
    // Configuration outputs
    input logic        ctrl_active_o,
    input logic [11:0] io_base_o,
    input logic        io_base_valid_o,
    input logic [3:0]  irq_line_o,
    input logic        dma_enable_o,
    input logic [1:0]  dma_channel_o,
    input logic [1:0]  intf_mode_o,
    input logic        second_drive_o,
    input logic [2:0]  data_rate_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_pulse;
        ack_o ##1 !ack_o;
    endsequence
    chk_ack_pulse: assert property (s_take |=> s_pulse)
        else $error("ack did not pulse once after a request");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    chk_rd_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_base_align: assert property (io_base_o[2:0] == 3'h0)
        else $error("io base not on an 8-byte boundary");
    chk_base_valid: assert property (io_base_valid_o == (io_base_o >= 12'h100))
        else $error("io base valid flag wrong");
    chk_mode_legal: assert property (intf_mode_o != 2'h2)
        else $error("reserved interface mode in use");
    chk_second_mode: assert property (second_drive_o |-> intf_mode_o == 2'h1)
        else $error("second drive reported outside second personality");
    chk_rate_code: assert property (data_rate_o <= 3'h4)
        else $error("data rate code out of range");
    // Software owned settings may only move after a bus cycle or a reset
    chk_cfg_write: assert property (!$stable({ctrl_active_o, irq_line_o, dma_enable_o, dma_channel_o})
        |-> ack_o || $past(ack_o) || $past(ack_o, 2) || $past(rst_i) || $past(rst_i, 2))
        else $error("configuration changed without a write");
endmodule
bind fcr_floppy_config fcr_floppy_config_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .ctrl_active_o(ctrl_active_o), .io_base_o(io_base_o),
    .io_base_valid_o(io_base_valid_o), .irq_line_o(irq_line_o), .dma_enable_o(dma_enable_o),
    .dma_channel_o(dma_channel_o), .intf_mode_o(intf_mode_o), .second_drive_o(second_drive_o),
    .data_rate_o(data_rate_o));

// ===== tb/tb_top.sv
// Self-checking bench for the floppy configuration bank
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [7:0] idx; logic [7:0] rst; logic [7:0] wv; logic [7:0] rv;} fcr_row_t;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [9:0]  adr_i = 0;
    logic [3:0]  sel_i = 0;
    logic [31:0] dat_i = 0;
    logic [1:0]  core_drive_sel_i = 0, core_motor_i = 0;
    logic        core_write_gate_i = 0, core_write_data_i = 0, core_unit_i = 0;
    logic        density_select_signal_i = 0, rate_bit1_i = 0, rate_bit0_i = 0, write_protect_pin_i = 1;
    wire  [31:0] dat_o;
    wire  [11:0] io_base_o;
    wire  [3:0]  irq_line_o;
    wire  [2:0]  data_rate_o;
    wire  [1:0]  dma_channel_o, intf_mode_o, tape_media_id_o, drive_sel_pin_o, motor_pin_o;
    wire         ack_o, ctrl_active_o, io_base_valid_o, dma_enable_o, second_drive_o, dma_burst_o;
    wire         three_mode_o, boot_drive_a_o, precomp_enable_o, write_protected_o;
    wire         write_gate_pin_o, write_data_pin_o, density_output_pin_o;
    int          failures = 0;
    int          check_count = 0;
    logic [31:0] rdat;
    // Unmapped index 31 closes the table: it must read zero and swallow writes
    fcr_row_t rows [11] = '{'{8'h30, 8'h01, 8'hff, 8'h01}, '{8'h60, 8'h03, 8'hff, 8'h0f},
        '{8'h61, 8'hf0, 8'hff, 8'hf8}, '{8'h70, 8'h06, 8'hff, 8'h0f}, '{8'h74, 8'h02, 8'hff, 8'h07},
        '{8'hf0, 8'h0e, 8'hff, 8'h7f}, '{8'hf1, 8'h00, 8'hff, 8'hff}, '{8'hf2, 8'h03, 8'hff, 8'h03},
        '{8'hf4, 8'h00, 8'hff, 8'h5b}, '{8'hf5, 8'h00, 8'hff, 8'h5b}, '{8'h31, 8'h00, 8'hff, 8'h00}};
    logic [7:0]  pf0 [6] = '{8'h24, 8'h44, 8'h54, 8'h54, 8'h54, 8'h24};
    logic [7:0]  pf1 [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00};
    logic [7:0]  pex [6] = '{8'h4a, 8'h35, 8'h4c, 8'h4e, 8'h4d, 8'h4b};
    logic        pwp [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
    logic [4:0]  mv [4] = '{5'h05, 5'h08, 5'h0c, 5'h02};
    logic [4:0]  me [4] = '{5'h0f, 5'h0a, 5'h1a, 5'h00};
    logic [2:0]  re [12] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h1, 3'h3, 3'h0, 3'h1, 3'h4, 3'h3, 3'h0};

    always #25 clk_i = ~clk_i;

    fcr_floppy_config dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .core_drive_sel_i, .core_motor_i, .core_write_gate_i, .core_write_data_i, .core_unit_i,
        .density_select_signal_i, .rate_bit1_i, .rate_bit0_i, .write_protect_pin_i, .ctrl_active_o,
        .io_base_o, .io_base_valid_o, .irq_line_o, .dma_enable_o, .dma_channel_o, .intf_mode_o,
        .second_drive_o, .dma_burst_o, .three_mode_o, .boot_drive_a_o, .tape_media_id_o,
        .precomp_enable_o, .data_rate_o, .write_protected_o, .drive_sel_pin_o, .motor_pin_o,
        .write_gate_pin_o, .write_data_pin_o, .density_output_pin_o);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v);
        int n;
        n = 0;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        sel_i <= 4'h1;
        dat_i <= {24'h0, v};
        @(posedge clk_i);
        while (ack_o !== 1'h1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
        begin
            failures++;
            $display("[FAIL] bus ack expected 1 seen %b", ack_o);
            results();
        end
        else
        begin
            rdat = dat_o;
            cyc_i <= 1'h0;
            stb_i <= 1'h0;
            @(posedge clk_i);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        acc(1'h1, idx, v);
    endtask

    // Three edges cover input registering plus the output flop
    task automatic st;
        repeat (3) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            acc(1'h0, rows[i].idx, 8'h0);
            chk($sformatf("reset of %h", rows[i].idx), {24'h0, rows[i].rst}, rdat);
            wr(rows[i].idx, rows[i].wv);
            acc(1'h0, rows[i].idx, 8'h0);
            chk($sformatf("readback of %h", rows[i].idx), {24'h0, rows[i].rv}, rdat);
        end
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        st();
        chk("reset cfg", 22'h27e0db,
            {ctrl_active_o, io_base_o, irq_line_o, dma_enable_o, dma_channel_o, intf_mode_o});
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h74, 8'(c));
            st();
            chk("dma", c > 3 ? 3'h0 : {1'h1, 2'(c)}, {dma_enable_o, dma_channel_o & {2{dma_enable_o}}});
        end
        wr(8'h60, 8'h0f);
        wr(8'h61, 8'hff);
        wr(8'h70, 8'hf9);
        wr(8'h30, 8'hfe);
        st();
        chk("active base irq", 18'h1ff89, {ctrl_active_o, io_base_valid_o, io_base_o, irq_line_o});
        wr(8'h61, 8'hff);
        wr(8'h60, 8'h00);
        st();
        chk("base low", 13'h00f8, {io_base_valid_o, io_base_o});
        wr(8'h60, 8'h01);
        wr(8'h61, 8'h00);
        st();
        chk("base edge", 13'h1100, {io_base_valid_o, io_base_o});
        foreach (mv[i])
        begin
            wr(8'hf0, {2'h0, i == 1, mv[i]});
            st();
            chk("mode", me[i], {intf_mode_o, second_drive_o, dma_burst_o, three_mode_o});
        end
        // Distinct select and motor codes so that a swap shows on both
        core_drive_sel_i <= 2'h1;
        core_motor_i <= 2'h2;
        core_write_gate_i <= 1'h1;
        foreach (pf0[i])
        begin
            wr(8'hf0, pf0[i]);
            wr(8'hf1, pf1[i]);
            write_protect_pin_i <= pwp[i];
            repeat (8) @(posedge clk_i);
            chk("pins", pex[i],
                {drive_sel_pin_o, motor_pin_o, write_gate_pin_o, write_data_pin_o, write_protected_o});
        end
        wr(8'hf1, 8'h60);
        st();
        chk("boot media", 3'h2, {boot_drive_a_o, tape_media_id_o});
        wr(8'hf1, 8'h10);
        st();
        chk("boot media", 3'h5, {boot_drive_a_o, tape_media_id_o});
        wr(8'hf1, 8'h00);
        for (int t = 0; t < 4; t++)
        begin
            wr(8'hf2, 8'(t));
            for (int p = 0; p < 8; p++)
            begin
                {density_select_signal_i, rate_bit1_i, rate_bit0_i} <= 3'(p);
                st();
                chk("density", t[0] ? (t[1] ? p[0] : p[1]) : p[2], density_output_pin_o);
            end
        end
        wr(8'hf2, 8'h00);
        for (int d = 0; d < 4; d++)
        begin
            wr(8'hf1, 8'(d << 2));
            density_select_signal_i <= d[0];
            st();
            chk("forced density", d[1] ? !d[0] : d[0], density_output_pin_o);
        end
        for (int k = 0; k < 12; k++)
        begin
            wr(8'hf4, 8'((k / 4) << 3));
            {rate_bit1_i, rate_bit0_i} <= 2'(k);
            st();
            chk("data rate", re[k], data_rate_o);
        end
        wr(8'hf5, 8'h40);
        core_unit_i <= 1'h1;
        st();
        chk("precomp unit1", 1'h0, precomp_enable_o);
        core_unit_i <= 1'h0;
        st();
        chk("precomp unit0", 1'h1, precomp_enable_o);
        results();
    end
endmodule
